/* File: bench/serial_lin_transmitter_bench.sv */
// Purpose: self-checking bench for the serial transmitter
// Assumes: zero-wait slave, bit time (1+1)*4 = 8 clocks
// Notes: frames are checked against a queue of expected words
`default_nettype none
module serial_lin_transmitter_bench
    import sci_tx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset, hsel, hwrite, hreadyout, hresp, tx_pin, irq, nine, rx_valid;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [9:0] rx_word;
    logic [9:0] exp_q[$];
    int bad_count, n_checks;
    serial_lin_transmitter serial_lin_transmitter_inst(.clk_sys(clk_sys), .reset(reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .tx_pin(tx_pin), .irq(irq));
    serial_rx_model #(.BIT_CLKS(8)) serial_rx_model_inst(.clk_sys(clk_sys), .line(tx_pin),
        .nine(nine), .valid(rx_valid), .word(rx_word));
    // free-running system clock, 25 ns period
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // one single AHB transfer; each phase held until hready seen high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin chk(32'h0, 32'h1, "bus answer"); wrap_up(); end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e, $sformatf("read %h", a));
        chk({31'h0, hresp}, 32'h0, "response");
    endtask
    // status access then data write; the frame is noted as expected
    task automatic send(input logic [8:0] w);
        bus(1'b0, OFF_STATUS, 32'h0);
        bus(1'b1, OFF_DATA, {24'h000000, w[7:0]});
        exp_q.push_back({1'b0, w});
    endtask
    // poll one status bit until it reaches the wanted value
    task automatic wait_st(input int idx, input logic v);
        int n;
        n = 0;
        do begin bus(1'b0, OFF_STATUS, 32'h0); n++; end while (rd[idx] !== v && n < 400);
        if (n >= 400) begin chk(32'h0, 32'h1, "status wait"); wrap_up(); end
    endtask
    // compare every received frame with the oldest expectation
    always @(posedge clk_sys) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk({22'h0, rx_word}, 32'hFFFFFFFF, "unexpected frame");
            else
                chk({22'h0, rx_word}, {22'h0, exp_q.pop_front()}, "frame");
        end
    end
    initial begin
        int n;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        nine = 1'b0;
        reset = 1'b1;
        seed = 32'h6B78;
        bad_count = 0;
        n_checks = 0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rchk(OFF_STATUS, 32'h7, 32'h3);
        rchk(OFF_BAUD, 32'hFF, {24'h0, RST_BAUD});
        rchk(OFF_PRESC, 32'hFF, {24'h0, RST_PRESC});
        rchk(8'h30, 32'hFFFFFFFF, 32'h0);
        bus(1'b1, OFF_STATUS, 32'h0);
        rchk(OFF_STATUS, 32'h3, 32'h3);
        bus(1'b1, OFF_BAUD, 32'h4);
        bus(1'b1, OFF_PRESC, 32'h1);
        bus(1'b1, OFF_IRQ_EN, 32'h3);
        bus(1'b1, OFF_CTRL_TWO, 32'h1);
        seed = xs(seed);
        send({1'b0, seed[7:0]});
        n = 4;
        while (tx_pin !== 1'b0 && n < 500) begin @(posedge clk_sys); n++; end
        chk(32'(n >= 80 && n < 500), 32'h1, "idle frame first");
        wait_st(ST_BUSY, 1'b0);
        seed = xs(seed);
        send({1'b0, seed[7:0]});
        #1;
        chk({31'h0, tx_pin}, 32'h0, "start at once");
        rchk(OFF_STATUS, 32'h3, 32'h1);
        send({1'b0, seed[15:8]});
        rchk(OFF_STATUS, 32'h1, 32'h0);
        wait_st(ST_TDE, 1'b1);
        rchk(OFF_STATUS, 32'h3, 32'h3);
        wait_st(ST_BUSY, 1'b0);
        // nine-bit words with the top bit clear and set
        for (int k = 0; k < 2; k++) begin
            nine <= 1'b1;
            bus(1'b1, OFF_CTRL_ONE, 32'((1 << CTL1_WLEN) | (k << CTL1_NINTH)));
            seed = xs(seed);
            send({k[0], seed[7:0]});
            wait_st(ST_BUSY, 1'b0);
        end
        nine <= 1'b0;
        // send_break must wait until LIN master mode is selected
        bus(1'b1, OFF_CTRL_TWO, 32'h3);
        repeat (4) @(posedge clk_sys);
        rchk(OFF_STATUS, 32'h4, 32'h0);
        exp_q.push_back({1'b1, 9'd13});
        bus(1'b1, OFF_CTRL_ONE, 32'(1 << CTL1_LIN));
        repeat (4) @(posedge clk_sys);
        wait_st(ST_BUSY, 1'b0);
        send(9'h055);
        wait_st(ST_BUSY, 1'b0);
        bus(1'b1, OFF_CTRL_TWO, 32'h5);
        bus(1'b1, OFF_IRQ_MASK, 32'h0);
        #1;
        chk({31'h0, irq}, 32'h0, "irq masked");
        bus(1'b1, OFF_IRQ_MASK, 32'h1);
        #1;
        chk({31'h0, irq}, 32'h1, "irq empty");
        send(9'h0A3);
        send(9'h0FF);
        #1;
        chk({31'h0, irq}, 32'h0, "irq buffer full");
        bus(1'b1, OFF_CTRL_TWO, 32'h9);
        #1;
        chk({31'h0, irq}, 32'h0, "irq done clear");
        wait_st(ST_BUSY, 1'b0);
        #1;
        chk({31'h0, irq}, 32'h1, "irq frame done");
        rchk(OFF_IRQ_STAT, 32'h3, 32'h3);
        bus(1'b1, OFF_IRQ_CLR, 32'h3);
        rchk(OFF_IRQ_STAT, 32'h3, 32'h0);
        repeat (20) @(posedge clk_sys);
        chk(32'(exp_q.size()), 32'h0, "frames left");
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: bench/serial_rx_model.sv */
// Purpose: receiving node at the far end of the transmit line
// Assumes: fixed bit time in system clocks, one stop bit
// Notes: a low stop bit is read as a break and its low length reported in bits
`default_nettype none
module serial_rx_model #(
    parameter int BIT_CLKS = 8
) (
    input wire logic clk_sys,
    input wire logic line,
    input wire logic nine,
    output logic valid,
    output logic [9:0] word
);
    timeunit 1ns;
    timeprecision 1ps;
    // sample each bit at its centre; word holds break flag then data
    initial begin
        int cnt;
        int nb;
        logic [8:0] d;
        valid = 1'b0;
        word = 10'h000;
        forever begin
            @(negedge line);
            d = 9'h000;
            nb = nine ? 9 : 8;
            repeat (BIT_CLKS / 2) @(posedge clk_sys);
            if (line !== 1'b0) continue;  // glitch, not a start bit
            for (int i = 0; i < nb; i++) begin
                repeat (BIT_CLKS) @(posedge clk_sys);
                d[i] = line;
            end
            repeat (BIT_CLKS) @(posedge clk_sys);
            cnt = BIT_CLKS / 2 + (nb + 1) * BIT_CLKS;
            if (line === 1'b1) begin
                word <= {1'b0, d};
            end else begin
                // bounded so a stuck-low line cannot hang the model
                while (line !== 1'b1 && cnt < 4000) begin
                    @(posedge clk_sys);
                    cnt++;
                end
                word <= {1'b1, 9'(cnt / BIT_CLKS)};
            end
            valid <= 1'b1;
            @(posedge clk_sys);
            valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: core/sci_tx_pkg.sv */
// Purpose: constants and types for the serial transmitter with LIN option
// Assumes: AHB-Lite register access, 32-bit words
// Notes: offsets are byte addresses
`default_nettype none
package sci_tx_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_CTRL_ONE = 8'h08;
    localparam logic [7:0] OFF_CTRL_TWO = 8'h0C;
    localparam logic [7:0] OFF_BAUD = 8'h10;
    localparam logic [7:0] OFF_PRESC = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_IRQ_EN = 8'h1C;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h20;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
    // field positions
    localparam int CTL1_NINTH = 0;
    localparam int CTL1_WLEN = 1;
    localparam int CTL1_LIN = 2;
    localparam int CTL2_TXON = 0;
    localparam int CTL2_SBK = 1;
    localparam int CTL2_TIE = 2;
    localparam int CTL2_FRAME_DONE_IRQ_EN = 3;
    localparam int ST_TDE = 0;
    localparam int ST_TC = 1;
    localparam int ST_BUSY = 2;
    localparam int EV_TDE = 0;
    localparam int EV_TC = 1;
    // reset values
    localparam logic [7:0] RST_BAUD = 8'h01;
    localparam logic [7:0] RST_PRESC = 8'h00;
    // frame lengths in bits
    localparam logic [4:0] BRK_BITS = 5'h0D;
    localparam logic [4:0] BITS_8 = 5'h0A;
    localparam logic [4:0] BITS_9 = 5'h0B;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DATA = 2'b01,
        TX_IDLEFRM = 2'b10,
        TX_BREAK = 2'b11
    } tx_state_t;
    typedef struct packed {
        logic sel;
        logic write;
        logic [7:0] addr;
    } ahb_req_t;
endpackage
`default_nettype wire

/* File: core/serial_lin_transmitter.sv */
// Purpose: transmit path of an asynchronous serial interface with LIN master break
// Assumes: single clock clk_sys at 40 MHz, AHB-Lite slave with zero wait states
// Notes: stop bit is one bit; frame holds start, data, stop
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`default_nettype none
// Overview of operation
// - with word-length select set, frames carry 9 data bits whose top bit is ninth_tx_bit.
// - data bits leave on the transmit pin least significant bit first.
// - the data register is a one-word holding buffer in front of the shift register.
// - setting tx_on sends one idle frame before any data frame.
// - holding_empty_flag clears on a status access followed by a data write.
// - holding_empty_flag sets when the buffer empties into the shift register.
// - the holding-empty interrupt needs its enable and the serial mask bit.
// - a data write during a frame waits in the buffer until that frame ends.
// - a data write while idle loads the shifter, starts at once, sets the empty flag.
// - frame_done_flag sets after a stop bit or break, interrupting if enabled and masked in.
// - frame_done_flag clears by the same status-then-data-write sequence.
// - the LIN select bit puts the transmitter in LIN master mode.
// - in LIN master mode send_break drives 13 low bit times.
module serial_lin_transmitter
    import sci_tx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic tx_pin,
    output logic irq
);
    ahb_req_t req_q;
    logic [7:0] ctl1_q, ctl2_q, baud_q, presc_q;
    logic mask_q;
    logic [1:0] irq_en_q, ev_q;
    logic tde_q, tc_q, stat_seen_q;
    logic [8:0] hold_q;
    logic hold_full_q, idle_pend_q;
    tx_state_t state_q;
    logic [10:0] shift_q;
    logic [4:0] bits_q;
    logic [15:0] tick_q;
    logic [3:0] pre_q;
    logic tx_q;
    logic wr_data, acc_stat, bit_end, frame_end, brk_req, tde_set;
    logic [4:0] data_bits;

    // address phase capture, zero wait states
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            req_q <= '0;
        end else if (hready) begin
            req_q.sel <= hsel && htrans[1];
            req_q.write <= hwrite;
            req_q.addr <= haddr[7:0];
        end
    end

    function automatic logic hit(input ahb_req_t r, input logic [7:0] off, input logic w);
        hit = r.sel && (r.write == w) && (r.addr == off);
    endfunction

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_data = hit(req_q, OFF_DATA, 1'b1);
    // any access to status arms the clearing sequence
    assign acc_stat = req_q.sel && (req_q.addr == OFF_STATUS);

    // read mux; unmapped addresses read zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (req_q.sel && !req_q.write) begin
            case (req_q.addr)
                OFF_STATUS: hrdata = {29'h0, state_q != TX_IDLE, tc_q, tde_q};
                OFF_DATA: hrdata = {23'h0, hold_q};
                OFF_CTRL_ONE: hrdata = {24'h0, ctl1_q};
                OFF_CTRL_TWO: hrdata = {24'h0, ctl2_q};
                OFF_BAUD: hrdata = {24'h0, baud_q};
                OFF_PRESC: hrdata = {24'h0, presc_q};
                OFF_IRQ_MASK: hrdata = {31'h0, mask_q};
                OFF_IRQ_EN: hrdata = {30'h0, irq_en_q};
                OFF_IRQ_STAT: hrdata = {30'h0, ev_q};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // control registers; send_break self-clears once taken
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctl1_q <= 8'h00;
            ctl2_q <= 8'h00;
            baud_q <= RST_BAUD;
            presc_q <= RST_PRESC;
            mask_q <= 1'b0;
            irq_en_q <= 2'b00;
        end else begin
            if (hit(req_q, OFF_CTRL_ONE, 1'b1)) ctl1_q <= hwdata[7:0];
            if (hit(req_q, OFF_BAUD, 1'b1)) baud_q <= hwdata[7:0];
            if (hit(req_q, OFF_PRESC, 1'b1)) presc_q <= hwdata[7:0];
            if (hit(req_q, OFF_IRQ_MASK, 1'b1)) mask_q <= hwdata[0];
            if (hit(req_q, OFF_IRQ_EN, 1'b1)) irq_en_q <= hwdata[1:0];
            if (hit(req_q, OFF_CTRL_TWO, 1'b1)) begin
                ctl2_q <= hwdata[7:0];
            end else if (brk_req) begin
                ctl2_q[CTL2_SBK] <= 1'b0;
            end
        end
    end

    // idle frame request on the rising edge of tx_on
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            idle_pend_q <= 1'b0;
        end else if (hit(req_q, OFF_CTRL_TWO, 1'b1) && hwdata[CTL2_TXON] && !ctl2_q[CTL2_TXON]) begin
            idle_pend_q <= 1'b1;
        end else if (state_q == TX_IDLE) begin
            idle_pend_q <= 1'b0;
        end
    end

    // break only in LIN master mode
    assign brk_req = ctl2_q[CTL2_SBK] && ctl1_q[CTL1_LIN] && state_q == TX_IDLE
        && !idle_pend_q && ctl2_q[CTL2_TXON];

    // baud tick: prescaler then divider, both whole counts
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pre_q <= 4'h0;
            tick_q <= 16'h0000;
        end else if (state_q == TX_IDLE) begin
            pre_q <= 4'h0;
            tick_q <= 16'h0000;
        end else if (pre_q >= presc_q[3:0]) begin
            pre_q <= 4'h0;
            tick_q <= bit_end ? 16'h0000 : tick_q + 16'h0001;
        end else begin
            pre_q <= pre_q + 4'h1;
        end
    end
    assign bit_end = (pre_q >= presc_q[3:0]) && (tick_q >= {8'h00, baud_q} - 16'h0001)
        && state_q != TX_IDLE;
    assign frame_end = bit_end && bits_q == 5'h01;
    assign data_bits = ctl1_q[CTL1_WLEN] ? BITS_9 : BITS_8;

    // frame sequencer and shifter; line idles high
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= TX_IDLE;
            shift_q <= 11'h7FF;
            bits_q <= 5'h00;
            tx_q <= 1'b1;
        end else begin
            case (state_q)
                TX_IDLE: begin
                    tx_q <= 1'b1;
                    if (!ctl2_q[CTL2_TXON]) begin
                        state_q <= TX_IDLE;
                    end else if (idle_pend_q) begin
                        state_q <= TX_IDLEFRM;
                        bits_q <= data_bits;
                        shift_q <= 11'h7FF;
                    end else if (brk_req) begin
                        state_q <= TX_BREAK;
                        bits_q <= BRK_BITS;
                        tx_q <= 1'b0;
                        shift_q <= 11'h000;
                    end else if (wr_data || hold_full_q) begin
                        // direct or buffered load when idle; stop high, start low, lsb next
                        state_q <= TX_DATA;
                        bits_q <= data_bits;
                        tx_q <= 1'b0;
                        shift_q <= wr_data ?
                            (ctl1_q[CTL1_WLEN] ? {1'b1, ctl1_q[CTL1_NINTH], hwdata[7:0], 1'b0}
                                               : {2'b11, hwdata[7:0], 1'b0}) :
                            (ctl1_q[CTL1_WLEN] ? {1'b1, hold_q, 1'b0}
                                               : {2'b11, hold_q[7:0], 1'b0});
                    end
                end
                default: begin
                    if (bit_end) begin
                        shift_q <= {1'b1, shift_q[10:1]};
                        tx_q <= (state_q == TX_BREAK) ? 1'b0 : shift_q[1];
                        bits_q <= bits_q - 5'h01;
                        if (frame_end) begin
                            state_q <= TX_IDLE;
                            tx_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
    assign tx_pin = tx_q;

    // holding buffer, takes a write while a frame is running
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hold_q <= 9'h000;
            hold_full_q <= 1'b0;
        end else if (wr_data && state_q != TX_IDLE) begin
            hold_q <= {ctl1_q[CTL1_NINTH], hwdata[7:0]};
            hold_full_q <= 1'b1;
        end else if (state_q == TX_IDLE && ctl2_q[CTL2_TXON] && !idle_pend_q && !brk_req) begin
            hold_full_q <= 1'b0;
        end
    end

    // a word moves into the shifter; shared by the flag and its sticky event
    assign tde_set = state_q == TX_IDLE && ctl2_q[CTL2_TXON] && !idle_pend_q && !brk_req
        && (wr_data || hold_full_q);

    // flags: set wins over the clearing sequence
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tde_q <= 1'b1;
            tc_q <= 1'b1;
            stat_seen_q <= 1'b0;
        end else begin
            if (acc_stat) stat_seen_q <= 1'b1;
            else if (wr_data) stat_seen_q <= 1'b0;
            if (tde_set) begin
                tde_q <= 1'b1;
            end else if (wr_data && stat_seen_q) begin
                tde_q <= 1'b0;
            end
            if (frame_end) begin
                tc_q <= 1'b1;
            end else if (wr_data && stat_seen_q) begin
                tc_q <= 1'b0;
            end
        end
    end

    // sticky events mark the moment a flag sets, so a write-one clear sticks while it stays
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ev_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == EV_TDE && tde_set) || (i == EV_TC && frame_end)) ev_q[i] <= 1'b1;
                else if (hit(req_q, OFF_IRQ_CLR, 1'b1) && hwdata[i]) ev_q[i] <= 1'b0;
            end
        end
    end

    // level interrupt: flag, own enable and serial mask bit all needed
    assign irq = mask_q && ((tde_q && ctl2_q[CTL2_TIE])
        || (tc_q && ctl2_q[CTL2_FRAME_DONE_IRQ_EN]));

    property p_break_low;
        @(posedge clk_sys) disable iff (reset)
        (state_q == TX_BREAK) |-> !tx_pin;
    endproperty
    a_break_low: assert property (p_break_low) else $error("break not low");

    property p_start_low;
        @(posedge clk_sys) disable iff (reset)
        ($past(state_q) == TX_IDLE && state_q == TX_DATA) |-> !tx_pin;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");

    property p_idle_high;
        @(posedge clk_sys) disable iff (reset)
        (state_q == TX_IDLEFRM) |-> tx_pin;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle frame not high");

    property p_tc_set;
        @(posedge clk_sys) disable iff (reset)
        frame_end |=> tc_q;
    endproperty
    a_tc_set: assert property (p_tc_set) else $error("frame done not set");

    property p_tde_clr;
        @(posedge clk_sys) disable iff (reset)
        (wr_data && stat_seen_q && state_q != TX_IDLE) |=> !tde_q;
    endproperty
    a_tde_clr: assert property (p_tde_clr) else $error("empty flag not cleared");

    property p_direct;
        @(posedge clk_sys) disable iff (reset)
        (wr_data && state_q == TX_IDLE && ctl2_q[CTL2_TXON] && !idle_pend_q && !brk_req)
            |=> (state_q == TX_DATA && tde_q);
    endproperty
    a_direct: assert property (p_direct) else $error("direct load failed");

    property p_hold;
        @(posedge clk_sys) disable iff (reset)
        (wr_data && state_q != TX_IDLE) |=> hold_full_q;
    endproperty
    a_hold: assert property (p_hold) else $error("holding buffer missed");

    property p_irq;
        @(posedge clk_sys) disable iff (reset)
        (tde_q && ctl2_q[CTL2_TIE] && mask_q) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_brk_len;
        @(posedge clk_sys) disable iff (reset)
        $rose(state_q == TX_BREAK) |-> bits_q == BRK_BITS;
    endproperty
    a_brk_len: assert property (p_brk_len) else $error("break length wrong");

    property p_irq_done;
        @(posedge clk_sys) disable iff (reset)
        (tc_q && ctl2_q[CTL2_FRAME_DONE_IRQ_EN] && mask_q) |-> irq;
    endproperty
    a_irq_done: assert property (p_irq_done) else $error("done irq missing");

    property p_irq_masked;
        @(posedge clk_sys) disable iff (reset)
        !mask_q |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq not masked");

    property p_tc_clr;
        @(posedge clk_sys) disable iff (reset)
        (wr_data && stat_seen_q && !frame_end) |=> !tc_q;
    endproperty
    a_tc_clr: assert property (p_tc_clr) else $error("frame done not cleared");

    property p_stop_high;
        @(posedge clk_sys) disable iff (reset)
        (state_q == TX_DATA && bits_q == 5'h01) |-> tx_pin;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

    property p_ev_tde;
        @(posedge clk_sys) disable iff (reset)
        tde_set |=> ev_q[EV_TDE];
    endproperty
    a_ev_tde: assert property (p_ev_tde) else $error("empty event missed");

    c_break: cover property (@(posedge clk_sys) state_q == TX_BREAK);
    c_data: cover property (@(posedge clk_sys) frame_end && state_q == TX_DATA);
    c_hold: cover property (@(posedge clk_sys) hold_full_q && frame_end);
    c_idle: cover property (@(posedge clk_sys) state_q == TX_IDLEFRM && frame_end);
    c_nine: cover property (@(posedge clk_sys) frame_end && state_q == TX_DATA && ctl1_q[CTL1_WLEN]);
endmodule
`default_nettype wire
